// *** core/relay_params.svh ***
// offsets, field positions, reset values and ranges of the relay select block
`ifndef RELAY_PARAMS_SVH
`define RELAY_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RLY_OFF_MAX_SW 8'h00
`define RLY_OFF_FUNC 8'h04
`define RLY_OFF_THR 8'h08
`define RLY_OFF_STATUS 8'h0C
`define RLY_OFF_IRQ_STAT 8'h10
`define RLY_OFF_IRQ_MASK 8'h14
`define RLY_OFF_CTRL 8'h18

// ****************************************************************
// reset values and ranges
// ****************************************************************
`define RLY_MAX_SW_RST 16'h0008
`define RLY_MAX_SW_MIN 16'h0004
`define RLY_MAX_SW_MAX 16'h0020
`define RLY_FUNC_RST 16'h0001
`define RLY_FUNC_MAX 16'h0009
`define RLY_THR_RST 16'h03E8
`define RLY_THR_MAX 16'h07D0
`define RLY_REF_ZERO 16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define RLY_RD_RED_BIT 8
`define RLY_ST_RELAY_BIT 0
`define RLY_ST_RED_BIT 1
`define RLY_ST_MAXRUN_BIT 2
`define RLY_ST_FREQ_LSB 8
`define RLY_IRQ_RISE_BIT 0
`define RLY_IRQ_FALL_BIT 1
`define RLY_IRQ_RED_BIT 2
`define RLY_IRQ_W 3
`define RLY_CTRL_INV_BIT 0

// ****************************************************************
// bus responses
// ****************************************************************
`define RLY_RESP_OKAY 2'h0
`define RLY_RESP_SLVERR 2'h2

`endif

// *** core/relay_pkg.sv ***
// types shared by the relay select block
package relay_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [3:0] {
    FN_RUNNING = 4'h0,
    FN_HEALTHY = 4'h1,
    FN_AT_TARGET = 4'h2,
    FN_TRIPPED = 4'h3,
    FN_FREQ_GE = 4'h4,
    FN_CURR_GE = 4'h5,
    FN_FREQ_LT = 4'h6,
    FN_CURR_LT = 4'h7,
    FN_AIN2_GT = 4'h8,
    FN_READY = 4'h9
  } relay_func_t;
endpackage

// *** core/relay_cond_select.sv ***
// picks the drive condition that the relay follows
module relay_cond_select (
  input wire relay_pkg::relay_func_t func_i,
  input wire relay_pkg::reg16_t thr_i,
  input wire logic running_i,
  input wire logic healthy_i,
  input wire logic at_target_i,
  input wire logic tripped_i,
  input wire logic ready_i,
  input wire relay_pkg::reg16_t out_freq_i,
  input wire relay_pkg::reg16_t motor_curr_i,
  input wire relay_pkg::reg16_t ain2_i,
  output logic cond_o
);
  import relay_pkg::*;

  // ****************************************************************
  // threshold compares, all in 0.1 % of rated value
  // ****************************************************************
  wire freq_ge = out_freq_i >= thr_i; // R17
  wire curr_ge = motor_curr_i >= thr_i;
  wire ain2_gt = ain2_i > thr_i;

  always_comb begin
    unique case (func_i)
      FN_RUNNING: cond_o = running_i; // R2
      FN_HEALTHY: cond_o = healthy_i; // R3
      FN_AT_TARGET: cond_o = at_target_i; // R4
      FN_TRIPPED: cond_o = tripped_i; // R5
      FN_FREQ_GE: cond_o = freq_ge; // R6
      FN_CURR_GE: cond_o = curr_ge; // R7
      FN_FREQ_LT: cond_o = ~freq_ge; // R8
      FN_CURR_LT: cond_o = ~curr_ge; // R9
      FN_AIN2_GT: cond_o = ain2_gt; // R10
      FN_READY: cond_o = ready_i & ~tripped_i; // R11
      default: cond_o = 1'b0;
    endcase
  end
endmodule

// *** core/relay_output_function_select.sv ***
// relay function select with switching frequency and register slave
// Operation
// R1 - function code accepts 0 to 9, resets to 1 (healthy)
// R2 - code 0: relay high while the drive is running
// R3 - code 1: relay high while powered and no fault exists
// R4 - code 2: relay high while output frequency equals target
// R5 - code 3: relay high while the drive is tripped
// R6 - code 4: relay high while output frequency at or above threshold
// R7 - code 5: relay high while motor current at or above threshold
// R8 - code 6: relay high while output frequency below threshold
// R9 - code 7: relay high while motor current below threshold
// R10 - code 8: relay high while analog input 2 exceeds threshold
// R11 - code 9: relay high while ready to run and not tripped
// R12 - threshold 0.0 to 200.0 percent, resets to 100.0, codes 4 to 8
// R13 - maximum switching frequency 4 to 32 kHz, resets to 8 kHz
// R14 - thermal derating reports reduced frequency and flags it on view
// R15 - inverted 10-0 V format runs at maximum when reference <= 0.0 %
// R16 - relay output registered, follows selection on the next edge
// R17 - thresholds compare quantities normalised to rated value
`include "relay_params.svh"
module relay_output_function_select (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire relay_pkg::addr_t s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire relay_pkg::addr_t s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic drive_running_i,
  input wire logic drive_healthy_i,
  input wire logic at_target_i,
  input wire logic drive_tripped_i,
  input wire logic ready_to_run_i,
  input wire relay_pkg::reg16_t out_freq_i,
  input wire relay_pkg::reg16_t motor_curr_i,
  input wire relay_pkg::reg16_t ain2_i,
  input wire relay_pkg::reg16_t ain1_ref_i,
  input wire logic heatsink_derate_i,
  input wire relay_pkg::reg16_t heatsink_limit_khz_i,
  output logic relay_o,
  output relay_pkg::reg16_t actual_switching_frequency_status_o,
  output logic thermal_reduction_indicator_o,
  output logic run_at_max_o,
  output logic irq_o
);
  import relay_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic aw_hold_ff;
  logic w_hold_ff;
  addr_t awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  reg16_t max_sw_ff;
  reg16_t func_ff;
  reg16_t thr_ff;
  logic inv_fmt_ff;
  logic [`RLY_IRQ_W-1:0] irq_stat_ff;
  logic [`RLY_IRQ_W-1:0] irq_mask_ff;
  logic relay_ff;
  reg16_t act_sw_ff;
  logic red_ff;
  logic run_max_ff;
  logic irq_ff;

  // ****************************************************************
  // byte lane merge
  // ****************************************************************
  function automatic reg16_t merge16(input reg16_t old_v,
                                     input logic [15:0] new_v,
                                     input logic [1:0] strb);
    reg16_t r;
    r[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
    r[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
    return r;
  endfunction

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire wr_max_sw = awaddr_ff == `RLY_OFF_MAX_SW;
  wire wr_func = awaddr_ff == `RLY_OFF_FUNC;
  wire wr_thr = awaddr_ff == `RLY_OFF_THR;
  wire wr_stat = awaddr_ff == `RLY_OFF_STATUS;
  wire wr_istat = awaddr_ff == `RLY_OFF_IRQ_STAT;
  wire wr_imask = awaddr_ff == `RLY_OFF_IRQ_MASK;
  wire wr_ctrl = awaddr_ff == `RLY_OFF_CTRL;
  wire wr_mapped = wr_max_sw | wr_func | wr_thr | wr_stat | wr_istat |
                   wr_imask | wr_ctrl;
  wire reg16_t sw_new = merge16(max_sw_ff, wdata_ff[15:0], wstrb_ff[1:0]);
  wire reg16_t fn_new = merge16(func_ff, wdata_ff[15:0], wstrb_ff[1:0]);
  wire reg16_t thr_new = merge16(thr_ff, wdata_ff[15:0], wstrb_ff[1:0]);
  wire sw_ok = sw_new >= `RLY_MAX_SW_MIN && sw_new <= `RLY_MAX_SW_MAX; // R13
  wire fn_ok = fn_new <= `RLY_FUNC_MAX; // R1
  wire thr_ok = thr_new <= `RLY_THR_MAX; // R12
  wire ld_sw = wr_fire & wr_max_sw & sw_ok;
  wire ld_fn = wr_fire & wr_func & fn_ok;
  wire ld_thr = wr_fire & wr_thr & thr_ok;
  wire ld_mask = wr_fire & wr_imask & wstrb_ff[0];
  wire ld_ctrl = wr_fire & wr_ctrl & wstrb_ff[0];
  wire [`RLY_IRQ_W-1:0] irq_clr = (wr_fire & wr_istat & wstrb_ff[0]) ?
                                  wdata_ff[`RLY_IRQ_W-1:0] :
                                  {`RLY_IRQ_W{1'b0}};
  wire [1:0] nxt_bresp = wr_mapped ? `RLY_RESP_OKAY : `RLY_RESP_SLVERR;

  // ****************************************************************
  // drive side logic
  // ****************************************************************
  logic cond;
  relay_cond_select u_cond (
    .func_i(relay_func_t'(func_ff[3:0])),
    .thr_i(thr_ff),
    .running_i(drive_running_i),
    .healthy_i(drive_healthy_i),
    .at_target_i(at_target_i),
    .tripped_i(drive_tripped_i),
    .ready_i(ready_to_run_i),
    .out_freq_i(out_freq_i),
    .motor_curr_i(motor_curr_i),
    .ain2_i(ain2_i),
    .cond_o(cond)
  );

  wire nxt_red = heatsink_derate_i & (heatsink_limit_khz_i < max_sw_ff);
  wire reg16_t nxt_act_sw = nxt_red ? heatsink_limit_khz_i : max_sw_ff;
  wire nxt_run_max = inv_fmt_ff &
                     ($signed(ain1_ref_i) <= $signed(`RLY_REF_ZERO)); // R15

  // ****************************************************************
  // interrupts
  // ****************************************************************
  wire [`RLY_IRQ_W-1:0] irq_set = {nxt_red & ~red_ff,
                                   relay_ff & ~cond,
                                   cond & ~relay_ff};
  wire [`RLY_IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  wire [`RLY_IRQ_W-1:0] nxt_irq_mask = ld_mask ?
                                       wdata_ff[`RLY_IRQ_W-1:0] : irq_mask_ff;
  wire nxt_irq = |(nxt_irq_stat & nxt_irq_mask);

  // ****************************************************************
  // read decode
  // ****************************************************************
  wire rd_fire = s_axi_arvalid_i & arready_ff;
  logic [31:0] rd_data;
  logic rd_hit;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i)
      `RLY_OFF_MAX_SW: begin
        rd_data[15:0] = max_sw_ff;
        rd_data[`RLY_RD_RED_BIT + 16] = red_ff; // R14
      end
      `RLY_OFF_FUNC: rd_data[15:0] = func_ff;
      `RLY_OFF_THR: rd_data[15:0] = thr_ff;
      `RLY_OFF_STATUS: begin
        rd_data[`RLY_ST_RELAY_BIT] = relay_ff;
        rd_data[`RLY_ST_RED_BIT] = red_ff;
        rd_data[`RLY_ST_MAXRUN_BIT] = run_max_ff;
        rd_data[`RLY_ST_FREQ_LSB +: 16] = act_sw_ff; // R14
      end
      `RLY_OFF_IRQ_STAT: rd_data[`RLY_IRQ_W-1:0] = irq_stat_ff;
      `RLY_OFF_IRQ_MASK: rd_data[`RLY_IRQ_W-1:0] = irq_mask_ff;
      `RLY_OFF_CTRL: rd_data[`RLY_CTRL_INV_BIT] = inv_fmt_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // write channel
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RLY_RESP_OKAY;
    end else begin
      awready_ff <= ~aw_hold_ff & ~(s_axi_awvalid_i & awready_ff);
      wready_ff <= ~w_hold_ff & ~(s_axi_wvalid_i & wready_ff);
      if (s_axi_awvalid_i & awready_ff) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid_i & wready_ff) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_hold_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RLY_RESP_OKAY;
    end else begin
      arready_ff <= ~rvalid_ff & ~rd_fire;
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_data;
        rresp_ff <= rd_hit ? `RLY_RESP_OKAY : `RLY_RESP_SLVERR;
      end else if (s_axi_rready_i & rvalid_ff) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // settings registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_sw_ff <= `RLY_MAX_SW_RST; // R13
      func_ff <= `RLY_FUNC_RST; // R1
      thr_ff <= `RLY_THR_RST; // R12
      inv_fmt_ff <= 1'b0;
      irq_mask_ff <= {`RLY_IRQ_W{1'b0}};
    end else begin
      if (ld_sw)
        max_sw_ff <= sw_new;
      if (ld_fn)
        func_ff <= fn_new;
      if (ld_thr)
        thr_ff <= thr_new;
      if (ld_ctrl)
        inv_fmt_ff <= wdata_ff[`RLY_CTRL_INV_BIT];
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_ff <= 1'b0;
      act_sw_ff <= `RLY_MAX_SW_RST;
      red_ff <= 1'b0;
      run_max_ff <= 1'b0;
      irq_stat_ff <= {`RLY_IRQ_W{1'b0}};
      irq_ff <= 1'b0;
    end else begin
      relay_ff <= cond; // R16
      act_sw_ff <= nxt_act_sw; // R14
      red_ff <= nxt_red; // R14
      run_max_ff <= nxt_run_max; // R15
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign relay_o = relay_ff;
  assign actual_switching_frequency_status_o = act_sw_ff;
  assign thermal_reduction_indicator_o = red_ff;
  assign run_at_max_o = run_max_ff;
  assign irq_o = irq_ff;
endmodule

// *** bench/relay_output_function_select_checker.sv ***
// port assertions for the relay function select block
module relay_output_function_select_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic heatsink_derate_i,
  input wire relay_pkg::reg16_t heatsink_limit_khz_i,
  input wire relay_pkg::reg16_t ain1_ref_i,
  input wire logic relay_o,
  input wire relay_pkg::reg16_t actual_switching_frequency_status_o,
  input wire logic thermal_reduction_indicator_o,
  input wire logic run_at_max_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import relay_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff rst_i;
  property p_reset;
    $fell(rst_i) |-> !relay_o && !s_axi_awready_o && !s_axi_bvalid_o &&
      actual_switching_frequency_status_o == 16'h0008;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle");
  property p_w_answer;
    s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("no write answer");
  property p_r_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_no_derate;
    !heatsink_derate_i |=> !thermal_reduction_indicator_o;
  endproperty
  a_no_derate: assert property (p_no_derate) else $error("no heat");
  property p_derate_val;
    thermal_reduction_indicator_o |->
      actual_switching_frequency_status_o == $past(heatsink_limit_khz_i);
  endproperty
  a_derate_val: assert property (p_derate_val) else $error("freq");
  property p_sw_range;
    !thermal_reduction_indicator_o |-> actual_switching_frequency_status_o
      inside {[16'h0004:16'h0020]};
  endproperty
  a_sw_range: assert property (p_sw_range) else $error("freq range");
  property p_max_run;
    run_at_max_o |-> $past(ain1_ref_i[15]) || $past(ain1_ref_i) == 16'h0000;
  endproperty
  a_max_run: assert property (p_max_run) else $error("max run");
endmodule

bind relay_output_function_select relay_output_function_select_checker u_chk (
  .clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .heatsink_derate_i, .heatsink_limit_khz_i, .ain1_ref_i, .relay_o,
  .actual_switching_frequency_status_o, .thermal_reduction_indicator_o,
  .run_at_max_o
);

// *** bench/relay_contact_model.sv ***
// contact circuit wired across the relay output
module relay_contact_model #(
  parameter int PULL_IN = 2
) (
  input wire logic clk_i,
  input wire logic coil_i,
  output logic closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_ff = 0;
  initial closed_o = 1'b0;
  // contact moves once the coil has held its new level for the pull-in time
  always @(posedge clk_i) begin
    if (coil_i === closed_o) begin
      cnt_ff <= 0;
    end else if (cnt_ff >= PULL_IN - 1) begin
      closed_o <= coil_i;
      cnt_ff <= 0;
    end else begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule

// *** bench/relay_output_function_select_test.sv ***
// self-checking bench for the relay function select block
`include "relay_params.svh"
module relay_output_function_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  import relay_pkg::*;
  logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, closed;
  logic running, healthy, at_tgt, tripped, ready, heat;
  logic awready, wready, bvalid, arready, rvalid, relay, ind, run_max, irq;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  addr_t awaddr, araddr;
  reg16_t freq, curr, ain2, ref1, limit, act;
  int miscompares, checked;
  relay_output_function_select uut (
    .clk_i, .rst_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .drive_running_i(running), .drive_healthy_i(healthy),
    .at_target_i(at_tgt), .drive_tripped_i(tripped), .ready_to_run_i(ready),
    .out_freq_i(freq), .motor_curr_i(curr), .ain2_i(ain2), .ain1_ref_i(ref1),
    .heatsink_derate_i(heat), .heatsink_limit_khz_i(limit), .relay_o(relay),
    .actual_switching_frequency_status_o(act),
    .thermal_reduction_indicator_o(ind), .run_at_max_o(run_max), .irq_o(irq)
  );
  relay_contact_model #(.PULL_IN(2)) contact (
    .clk_i, .coil_i(relay), .closed_o(closed)
  );
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(addr_t a, logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(addr_t a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr_ok(addr_t a, logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk("bresp", 32'(rs), 32'(`RLY_RESP_OKAY));
  endtask
  task automatic rd_chk(addr_t a, logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk("rdata", v, e);
    chk("rresp", 32'(rs), 32'(`RLY_RESP_OKAY));
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // drive pattern v, frequency and current on either side of 100.0 percent
  task automatic apply(logic [2:0] v);
    @(posedge clk_i);
    {at_tgt, healthy, running} <= v;
    tripped <= ~v[1];
    ready <= v[0] | v[2];
    freq <= v[0] ? 16'h03E8 : 16'h03E7;
    curr <= v[1] ? 16'h03E8 : 16'h03E7;
    ain2 <= v[2] ? 16'h03E9 : 16'h03E8;
    tick(1);
  endtask
  function automatic logic exp_relay(int c, logic [2:0] v);
    logic [9:0] t;
    t = {(v[0] | v[2]) & v[1], v[2], ~v[1], ~v[0], v[1], v[0], ~v[1], v[2],
      v[1], v[0]};
    return t[c];
  endfunction
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial begin
    logic [15:0] sw_w [4];
    logic [15:0] sw_e [4];
    logic [31:0] rst_e [7];
    logic e;
    sw_w = '{16'h0003, 16'h0021, 16'h0004, 16'h0020};
    sw_e = '{16'h0008, 16'h0008, 16'h0004, 16'h0020};
    rst_e = '{32'h8, 32'h1, 32'h3E8, 32'h800, 32'h0, 32'h0, 32'h0};
    {miscompares, checked} = '0;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {wdata, wstrb, running, healthy, at_tgt, tripped, ready, heat} = '0;
    {freq, curr, ain2, ref1, limit} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), rst_e[i]);
    rd(8'h1C, d, r);
    chk("unmapped rdata", d, 32'h0);
    chk("unmapped rresp", 32'(r), 32'(`RLY_RESP_SLVERR));
    wr(8'h1C, 32'h1, r);
    chk("unmapped bresp", 32'(r), 32'(`RLY_RESP_SLVERR));
    wr_ok(`RLY_OFF_STATUS, 32'hFFFF_FFFF);
    for (int c = 0; c < 10; c++) begin
      wr_ok(`RLY_OFF_FUNC, 32'(c));
      for (int v = 0; v < 8; v++) begin
        apply(3'(v));
        e = exp_relay(c, 3'(v));
        chk("relay", 32'(relay), 32'(e));
      end
    end
    wr_ok(`RLY_OFF_FUNC, 32'hA);
    rd_chk(`RLY_OFF_FUNC, 32'h9);
    apply(3'h3);
    tick(3);
    chk("contact", 32'(closed), 32'h1);
    wr_ok(`RLY_OFF_THR, 32'h7D1);
    rd_chk(`RLY_OFF_THR, 32'h3E8);
    wr_ok(`RLY_OFF_THR, 32'h7D0);
    rd_chk(`RLY_OFF_THR, 32'h7D0);
    wr_ok(`RLY_OFF_FUNC, 32'h4);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      freq <= 16'h07D0 - 16'(i);
      tick(2);
      chk("relay", 32'(relay), 32'(i == 0));
    end
    for (int i = 0; i < 4; i++) begin
      wr_ok(`RLY_OFF_MAX_SW, 32'(sw_w[i]));
      rd_chk(`RLY_OFF_MAX_SW, 32'(sw_e[i]));
    end
    @(posedge clk_i);
    heat <= 1'b1;
    limit <= 16'h0006;
    tick(2);
    chk("indicator", 32'(ind), 32'h1);
    chk("actual", 32'(act), 32'h6);
    rd_chk(`RLY_OFF_MAX_SW, 32'h0100_0020);
    @(posedge clk_i);
    limit <= 16'h0028;
    tick(2);
    chk("actual", 32'(act), 32'h20);
    chk("indicator", 32'(ind), 32'h0);
    wr_ok(`RLY_OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      ref1 <= (i == 2) ? 16'hFFFF : 16'(i);
      tick(2);
      chk("run_at_max", 32'(run_max), 32'(i != 1));
    end
    wr_ok(`RLY_OFF_CTRL, 32'h0);
    tick(2);
    chk("run_at_max", 32'(run_max), 32'h0);
    rd_chk(`RLY_OFF_IRQ_STAT, 32'h7);
    wr_ok(`RLY_OFF_IRQ_STAT, 32'h7);
    @(posedge clk_i);
    freq <= 16'h07D0;
    tick(0);
    chk("relay", 32'(relay), 32'h0);
    tick(1);
    chk("relay", 32'(relay), 32'h1);
    tick(1);
    rd_chk(`RLY_OFF_IRQ_STAT, 32'h1);
    chk("irq", 32'(irq), 32'h0);
    wr_ok(`RLY_OFF_IRQ_MASK, 32'h1);
    tick(1);
    chk("irq", 32'(irq), 32'h1);
    wr_ok(`RLY_OFF_IRQ_STAT, 32'h1);
    tick(1);
    chk("irq", 32'(irq), 32'h0);
    rd_chk(`RLY_OFF_IRQ_STAT, 32'h0);
    summarize();
  end
endmodule
